// *** rtl/pwr_mode_pkg.sv ***
// Constants and types for the drive power-mode manager
package pwr_mode_pkg;
    localparam logic [7:0] OP_STBY_IMM_A = 8'h94;
    localparam logic [7:0] OP_STBY_IMM_B = 8'he0;
    localparam logic [7:0] OP_IDLE_IMM_A = 8'h95;
    localparam logic [7:0] OP_IDLE_IMM_B = 8'he1;
    localparam logic [7:0] OP_STBY_A = 8'h96;
    localparam logic [7:0] OP_STBY_B = 8'he2;
    localparam logic [7:0] OP_IDLE_A = 8'h97;
    localparam logic [7:0] OP_IDLE_B = 8'he3;
    localparam logic [7:0] OP_CHECK_A = 8'h98;
    localparam logic [7:0] OP_CHECK_B = 8'he5;
    localparam logic [7:0] OP_SLEEP_A = 8'h99;
    localparam logic [7:0] OP_SLEEP_B = 8'he6;
    localparam logic [7:0] PM_CODE_SPUN = 8'hff;
    localparam logic [7:0] PM_CODE_STBY = 8'h00;
    localparam logic [7:0] TMO_OFF = 8'h00;
    localparam logic [7:0] TMO_SEC_MAX = 8'hf0;
    localparam logic [7:0] TMO_HALF_MAX = 8'hfb;
    localparam logic [7:0] TMO_21MIN = 8'hfc;
    localparam logic [7:0] TMO_VENDOR = 8'hfd;
    localparam logic [7:0] TMO_RSVD = 8'hfe;
    localparam logic [7:0] TMO_21M15 = 8'hff;
    // Interval lengths in 5 s ticks
    localparam logic [12:0] TICKS_PER_HALF_HOUR = 13'h0168;
    localparam logic [12:0] TICKS_21MIN = 13'h00fc;
    localparam logic [12:0] TICKS_10H = 13'h1c20;
    localparam logic [12:0] TICKS_21M15 = 13'h00ff;
    localparam int CLK_HZ = 50000000;
    localparam int TICK_SEC = 5;
    localparam longint TICK_CYCLES = longint'(CLK_HZ) * TICK_SEC;
    typedef enum logic [4:0] {
        PM_ACTIVE = 5'b00001,
        PM_IDLE = 5'b00010,
        PM_STANDBY = 5'b00100,
        PM_SPINUP = 5'b01000,
        PM_SLEEP = 5'b10000
    } pm_state_t;
    typedef enum logic [2:0] {
        CMD_NONE, CMD_STBY_IMM, CMD_IDLE_IMM, CMD_STBY, CMD_IDLE, CMD_CHECK, CMD_SLEEP
    } pm_cmd_t;
endpackage

// *** rtl/pm_cmd_decode.sv ***
// Opcode decoder for power-mode commands
`timescale 1ns/10ps
`default_nettype none
module pm_cmd_decode
    import pwr_mode_pkg::*;
(
    input wire logic [7:0] opcode,
    output pwr_mode_pkg::pm_cmd_t cmd
);
    always_comb begin
        unique case (opcode)
            OP_STBY_IMM_A, OP_STBY_IMM_B: cmd = CMD_STBY_IMM;
            OP_IDLE_IMM_A, OP_IDLE_IMM_B: cmd = CMD_IDLE_IMM;
            OP_STBY_A, OP_STBY_B: cmd = CMD_STBY;
            OP_IDLE_A, OP_IDLE_B: cmd = CMD_IDLE;
            OP_CHECK_A, OP_CHECK_B: cmd = CMD_CHECK;
            OP_SLEEP_A, OP_SLEEP_B: cmd = CMD_SLEEP;
            default: cmd = CMD_NONE;
        endcase
    end
endmodule
`default_nettype wire

// *** rtl/pm_tick_gen.sv ***
// Five-second tick generator for the power-down timer
`timescale 1ns/10ps
`default_nettype none
module pm_tick_gen
    import pwr_mode_pkg::*;
#(
    parameter logic [31:0] TICK_LEN = 32'(TICK_CYCLES)
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic restart,
    output logic tick
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    always_comb begin
        tick = (cnt_r == TICK_LEN - 32'h1);
        if (restart || tick) begin
            cnt_nxt = 32'h0;
        end else begin
            cnt_nxt = cnt_r + 32'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cnt_r <= 32'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// *** rtl/drive_power_mode_manager.sv ***
// Power-mode manager: command handling, power states and auto power-down
// Notes on behaviour
// - Standby immediate spins down, keeps timeout
// - Idle immediate spins up if stopped, keeps timeout
// - Standby sets timeout; countdown starts on idle
// - Idle sets timeout; countdown starts immediately
// - Codes 1-240 x5 s; 241-251 x30 min
// - 252=21 min, 253=10 h, 255=21m15s
// - Check mode returns ffh spun, 00h standby
// - Sleep spins down and enters sleep
// - Only resets leave sleep
// - Power-on state is active
// - Busy clears once change begins, with interrupt in same cycle
// - Sleep holds busy until motor stops
// - Timer expiry enters standby
// - Disk command in standby busy until speed
// - Disk command completion restarts timeout
`timescale 1ns/10ps
`default_nettype none
module drive_power_mode_manager
    import pwr_mode_pkg::*;
#(
    parameter logic [31:0] TICK_LEN = 32'(TICK_CYCLES)
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic soft_reset,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic [7:0] cmd_count,
    input wire logic disk_cmd_done,
    input wire logic motor_at_speed,
    input wire logic motor_stopped,
    output logic busy_status_flag,
    output logic cmd_irq,
    output logic [7:0] count_out,
    output logic count_out_valid,
    output logic spin_up_req,
    output logic spin_down_req,
    output pwr_mode_pkg::pm_state_t pm_state
);
    import pwr_mode_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Motor status comes from the spindle domain, so two flops first
    logic [1:0] speed_sync_r;
    logic [1:0] stop_sync_r;
    logic at_speed;
    logic stopped;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            speed_sync_r <= 2'b00;
            stop_sync_r <= 2'b00;
        end else begin
            speed_sync_r <= {speed_sync_r[0], motor_at_speed};
            stop_sync_r <= {stop_sync_r[0], motor_stopped};
        end
    end
    assign at_speed = speed_sync_r[1];
    assign stopped = stop_sync_r[1];

    // ----------------------------------------
    // Decode and timeout conversion
    // ----------------------------------------
    pm_cmd_t cmd;
    pm_cmd_decode u_dec (
        .opcode(cmd_opcode),
        .cmd(cmd)
    );

    function automatic logic [12:0] tmo_ticks(input logic [7:0] code);
        logic [12:0] t;
        t = 13'h0;
        if (code == TMO_OFF || code == TMO_RSVD) begin
            t = 13'h0;
        end else if (code <= TMO_SEC_MAX) begin
            t = {5'h0, code};
        end else if (code <= TMO_HALF_MAX) begin
            t = 13'(32'(code - TMO_SEC_MAX) * 32'(TICKS_PER_HALF_HOUR));
        end else if (code == TMO_21MIN) begin
            t = TICKS_21MIN;
        end else if (code == TMO_VENDOR) begin
            t = TICKS_10H;
        end else begin
            t = TICKS_21M15;
        end
        return t;
    endfunction

    // Commands are ignored in sleep; only a reset wakes the drive
    pm_state_t pm_state_r, pm_state_nxt;
    logic take;
    logic sleeping;
    assign sleeping = (pm_state_r == PM_SLEEP);
    assign take = cmd_valid && !sleeping;

    // ----------------------------------------
    // Five-second tick
    // ----------------------------------------
    logic tick;
    logic tick_restart;
    assign tick_restart = take || disk_cmd_done;
    pm_tick_gen #(.TICK_LEN(TICK_LEN)) u_tick (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .restart(tick_restart),
        .tick(tick)
    );

    // ----------------------------------------
    // Power state machine
    // ----------------------------------------
    logic [12:0] tmo_load_r, tmo_load_nxt;
    logic [12:0] tmo_cnt_r, tmo_cnt_nxt;
    logic tmo_run_r, tmo_run_nxt;
    logic busy_r, busy_nxt;
    logic irq_r, irq_nxt;
    logic [7:0] cnt_out_r, cnt_out_nxt;
    logic cnt_vld_r, cnt_vld_nxt;
    logic up_r, up_nxt;
    logic down_r, down_nxt;
    logic sleep_wait_r, sleep_wait_nxt;
    logic spin_wait_r, spin_wait_nxt;
    logic spun;
    assign spun = (pm_state_r == PM_ACTIVE) || (pm_state_r == PM_IDLE);

    always_comb begin
        pm_state_nxt = pm_state_r;
        tmo_load_nxt = tmo_load_r;
        tmo_cnt_nxt = tmo_cnt_r;
        tmo_run_nxt = tmo_run_r;
        busy_nxt = busy_r;
        irq_nxt = 1'b0;
        cnt_out_nxt = cnt_out_r;
        cnt_vld_nxt = 1'b0;
        up_nxt = 1'b0;
        down_nxt = 1'b0;
        sleep_wait_nxt = sleep_wait_r;
        spin_wait_nxt = spin_wait_r;
        // Countdown while enabled and spinning; a new command beats expiry
        if (tmo_run_r && tmo_load_r != 13'h0 && spun && tick && !take) begin
            if (tmo_cnt_r <= 13'h1) begin
                pm_state_nxt = PM_STANDBY;
                down_nxt = 1'b1;
                tmo_run_nxt = 1'b0;
            end else begin
                tmo_cnt_nxt = tmo_cnt_r - 13'h1;
            end
        end
        if (take) begin
            tmo_cnt_nxt = tmo_load_r;
            busy_nxt = 1'b1;
            unique case (cmd)
                CMD_STBY_IMM: begin
                    pm_state_nxt = PM_STANDBY;
                    down_nxt = !stopped;
                    irq_nxt = 1'b1;
                    busy_nxt = 1'b0;
                end
                CMD_IDLE_IMM: begin
                    pm_state_nxt = PM_IDLE;
                    up_nxt = !spun;
                    tmo_run_nxt = 1'b1;
                    irq_nxt = 1'b1;
                    busy_nxt = 1'b0;
                end
                CMD_STBY: begin
                    pm_state_nxt = PM_STANDBY;
                    down_nxt = !stopped;
                    tmo_load_nxt = tmo_ticks(cmd_count);
                    tmo_cnt_nxt = tmo_ticks(cmd_count);
                    tmo_run_nxt = 1'b0;
                    irq_nxt = 1'b1;
                    busy_nxt = 1'b0;
                end
                CMD_IDLE: begin
                    pm_state_nxt = PM_IDLE;
                    up_nxt = !spun;
                    tmo_load_nxt = tmo_ticks(cmd_count);
                    tmo_cnt_nxt = tmo_ticks(cmd_count);
                    tmo_run_nxt = 1'b1;
                    irq_nxt = 1'b1;
                    busy_nxt = 1'b0;
                end
                CMD_CHECK: begin
                    cnt_out_nxt = spun ? PM_CODE_SPUN : PM_CODE_STBY;
                    cnt_vld_nxt = 1'b1;
                    irq_nxt = 1'b1;
                    busy_nxt = 1'b0;
                end
                CMD_SLEEP: begin
                    down_nxt = !stopped;
                    sleep_wait_nxt = 1'b1;
                end
                CMD_NONE: begin
                    // Disk command: standby needs spin-up first
                    if (!spun) begin
                        pm_state_nxt = PM_SPINUP;
                        up_nxt = 1'b1;
                        spin_wait_nxt = 1'b1;
                    end else begin
                        busy_nxt = 1'b0;
                        pm_state_nxt = PM_ACTIVE;
                    end
                end
            endcase
        end
        if (sleep_wait_r && stopped) begin
            sleep_wait_nxt = 1'b0;
            pm_state_nxt = PM_SLEEP;
            busy_nxt = 1'b0;
            irq_nxt = 1'b1;
        end
        if (spin_wait_r && at_speed) begin
            spin_wait_nxt = 1'b0;
            pm_state_nxt = PM_ACTIVE;
            busy_nxt = 1'b0;
        end
        if (disk_cmd_done && !take) begin
            tmo_cnt_nxt = tmo_load_r;
            tmo_run_nxt = (tmo_load_r != 13'h0);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b || soft_reset) begin
            pm_state_r <= PM_ACTIVE;
            tmo_load_r <= 13'h0;
            tmo_cnt_r <= 13'h0;
            tmo_run_r <= 1'b0;
            busy_r <= 1'b0;
            irq_r <= 1'b0;
            cnt_out_r <= 8'h00;
            cnt_vld_r <= 1'b0;
            up_r <= 1'b0;
            down_r <= 1'b0;
            sleep_wait_r <= 1'b0;
            spin_wait_r <= 1'b0;
        end else begin
            pm_state_r <= pm_state_nxt;
            tmo_load_r <= tmo_load_nxt;
            tmo_cnt_r <= tmo_cnt_nxt;
            tmo_run_r <= tmo_run_nxt;
            busy_r <= busy_nxt;
            irq_r <= irq_nxt;
            cnt_out_r <= cnt_out_nxt;
            cnt_vld_r <= cnt_vld_nxt;
            up_r <= up_nxt;
            down_r <= down_nxt;
            sleep_wait_r <= sleep_wait_nxt;
            spin_wait_r <= spin_wait_nxt;
        end
    end

    assign busy_status_flag = busy_r;
    assign cmd_irq = irq_r;
    assign count_out = cnt_out_r;
    assign count_out_valid = cnt_vld_r;
    assign spin_up_req = up_r;
    assign spin_down_req = down_r;
    assign pm_state = pm_state_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_por_active: assert property (@(posedge ref_clk)
        !rst_b |=> pm_state_r == PM_ACTIVE)
        else $error("not active after reset");
    a_sleep_sticks: assert property (@(posedge ref_clk)
        disable iff (!rst_b || soft_reset)
        sleeping && !soft_reset |=> sleeping)
        else $error("left sleep without reset");
    a_stby_imm: assert property (@(posedge ref_clk)
        disable iff (!rst_b || soft_reset)
        take && cmd == CMD_STBY_IMM |=> pm_state_r == PM_STANDBY && irq_r && !busy_r)
        else $error("standby immediate wrong");
    a_idle_imm: assert property (@(posedge ref_clk)
        disable iff (!rst_b || soft_reset)
        take && cmd == CMD_IDLE_IMM |=> pm_state_r == PM_IDLE && irq_r)
        else $error("idle immediate wrong");
    a_stby_load: assert property (@(posedge ref_clk)
        disable iff (!rst_b || soft_reset)
        take && cmd == CMD_STBY && cmd_count == 8'h01 |=> tmo_load_r == 13'h1 && !tmo_run_r)
        else $error("standby timeout load wrong");
    a_idle_load: assert property (@(posedge ref_clk)
        disable iff (!rst_b || soft_reset)
        take && cmd == CMD_IDLE && cmd_count == 8'hf1 |=> tmo_load_r == TICKS_PER_HALF_HOUR
        && tmo_run_r)
        else $error("idle timeout load wrong");
    a_code_252: assert property (@(posedge ref_clk)
        disable iff (!rst_b || soft_reset)
        take && cmd == CMD_IDLE && cmd_count == TMO_21MIN |=> tmo_load_r == TICKS_21MIN)
        else $error("code 252 wrong");
    a_check_code: assert property (@(posedge ref_clk)
        disable iff (!rst_b || soft_reset)
        take && cmd == CMD_CHECK |=> cnt_vld_r
        && cnt_out_r == ($past(spun) ? PM_CODE_SPUN : PM_CODE_STBY))
        else $error("check power mode code wrong");
    a_sleep_busy: assert property (@(posedge ref_clk)
        disable iff (!rst_b || soft_reset)
        sleep_wait_r && !stopped |=> busy_r && !irq_r)
        else $error("sleep busy released early");
    a_spinup_busy: assert property (@(posedge ref_clk)
        disable iff (!rst_b || soft_reset)
        pm_state_r == PM_SPINUP |-> busy_r)
        else $error("busy low during spin-up");
    c_sleep: cover property (@(posedge ref_clk) disable iff (!rst_b)
        take && cmd == CMD_SLEEP ##[1:20] sleeping);
    c_auto_stby: cover property (@(posedge ref_clk) disable iff (!rst_b)
        spun ##1 pm_state_r == PM_STANDBY && down_r && !$past(take));
    c_spinup: cover property (@(posedge ref_clk) disable iff (!rst_b)
        pm_state_r == PM_SPINUP ##[1:20] pm_state_r == PM_ACTIVE);
endmodule
`default_nettype wire

// *** test/motor_model.sv ***
// Behavioural spindle motor that answers the spin requests
`timescale 1ns/10ps
`default_nettype none
module motor_model #(
    parameter int DLY = 6
) (
    input wire logic ref_clk,
    input wire logic spin_up_req,
    input wire logic spin_down_req,
    output logic motor_at_speed,
    output logic motor_stopped
);
    int cnt;
    logic going_up;
    initial begin
        motor_at_speed = 1'b1;
        motor_stopped = 1'b0;
        cnt = 0;
        going_up = 1'b1;
    end
    // ---------------------------------------------
    // Speed changes
    // ---------------------------------------------
    // Slow on purpose, so the busy windows are long enough to see
    always @(posedge ref_clk) begin
        if (spin_up_req === 1'b1) begin
            going_up <= 1'b1;
            motor_stopped <= 1'b0;
            cnt <= DLY;
        end else if (spin_down_req === 1'b1) begin
            going_up <= 1'b0;
            motor_at_speed <= 1'b0;
            cnt <= DLY;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            motor_at_speed <= going_up;
            motor_stopped <= !going_up;
        end
    end
endmodule
`default_nettype wire

// *** test/drive_power_mode_manager_tb_top.sv ***
// Self-checking bench for the power-mode manager
`timescale 1ns/10ps
`default_nettype none
module drive_power_mode_manager_tb_top;
    import pwr_mode_pkg::*;
    localparam logic [31:0] TLEN = 32'd10;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic soft_reset = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_opcode = 8'h00;
    logic [7:0] cmd_count = 8'h00;
    logic disk_cmd_done = 1'b0;
    logic motor_at_speed, motor_stopped, busy_status_flag, cmd_irq;
    logic count_out_valid, spin_up_req, spin_down_req;
    logic [7:0] count_out;
    pm_state_t pm_state;
    int mismatches = 0;
    int tests_run = 0;
    int seed = 86;
    int n;
    logic [7:0] exp_q[$];

    always #10 ref_clk = ~ref_clk;

    motor_model motor_model_i (.ref_clk(ref_clk), .spin_up_req(spin_up_req),
        .spin_down_req(spin_down_req), .motor_at_speed(motor_at_speed),
        .motor_stopped(motor_stopped));

    drive_power_mode_manager #(.TICK_LEN(TLEN)) drive_power_mode_manager_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .soft_reset(soft_reset),
        .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_count(cmd_count),
        .disk_cmd_done(disk_cmd_done), .motor_at_speed(motor_at_speed),
        .motor_stopped(motor_stopped), .busy_status_flag(busy_status_flag),
        .cmd_irq(cmd_irq), .count_out(count_out), .count_out_valid(count_out_valid),
        .spin_up_req(spin_up_req), .spin_down_req(spin_down_req), .pm_state(pm_state));

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] op, input logic [7:0] cnt);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_opcode = op;
        cmd_count = cnt;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
    endtask

    task automatic wait_state(input pm_state_t s, input int bound, output int cyc);
        cyc = 0;
        while (pm_state !== s && cyc < bound) begin
            @(negedge ref_clk);
            cyc++;
        end
        if (pm_state !== s) begin
            mismatches++;
            $display("ERROR t=%0t state seen=%h want=%h", $time, pm_state, s);
            stop_test();
        end
    endtask

    task automatic wait_busy_low(input int bound);
        int c;
        c = 0;
        while (busy_status_flag !== 1'b0 && c < bound) begin
            @(negedge ref_clk);
            c++;
        end
        if (busy_status_flag !== 1'b0) begin
            mismatches++;
            $display("ERROR t=%0t busy seen=%h want=%h", $time, busy_status_flag, 1'b0);
            stop_test();
        end
    endtask

    // ---------------------------------------------
    // Result watcher
    // ---------------------------------------------
    always @(negedge ref_clk) begin
        if (count_out_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(count_out, 8'h5a);
            end else begin
                check(count_out, exp_q.pop_front());
            end
        end
    end

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        check(8'(pm_state), 8'(PM_ACTIVE));
        exp_q.push_back(PM_CODE_SPUN);
        send(OP_CHECK_A, 8'h00);
        check({7'h0, cmd_irq}, 8'h01);
        $display("test power-on check done");

        // Count is ignored, so the disabled timeout must survive
        send(OP_STBY_IMM_B, 8'($random(seed)));
        check({6'h0, spin_down_req, busy_status_flag}, 8'h02);
        check(8'(pm_state), 8'(PM_STANDBY));
        exp_q.push_back(PM_CODE_STBY);
        send(OP_CHECK_B, 8'h00);
        send(OP_IDLE_IMM_A, 8'($random(seed)));
        check({7'h0, spin_up_req}, 8'h01);
        repeat (50) @(negedge ref_clk);
        check(8'(pm_state), 8'(PM_IDLE));
        exp_q.push_back(PM_CODE_SPUN);
        send(OP_CHECK_A, 8'h00);
        $display("test immediate commands done");

        send(OP_IDLE_B, 8'h02);
        check({6'h0, spin_up_req, cmd_irq}, 8'h01);
        wait_state(PM_STANDBY, 60, n);
        check(8'(n >= 15 && n <= 24), 8'h01);
        $display("test auto power-down done");

        send(OP_STBY_A, 8'h01);
        check(8'(pm_state), 8'(PM_STANDBY));
        send(8'h20, 8'h01);
        check({7'h0, busy_status_flag}, 8'h01);
        wait_busy_low(60);
        check({7'h0, motor_at_speed}, 8'h01);
        @(negedge ref_clk);
        disk_cmd_done = 1'b1;
        @(negedge ref_clk);
        disk_cmd_done = 1'b0;
        wait_state(PM_STANDBY, 40, n);
        check(8'(n >= 8 && n <= 12), 8'h01);
        $display("test disk command in standby done");

        send(OP_IDLE_A, 8'h00);
        check({7'h0, spin_up_req}, 8'h01);
        repeat (60) @(negedge ref_clk);
        check(8'(pm_state), 8'(PM_IDLE));
        $display("test timeout disable done");

        // Long interval codes; each idle or standby command replaces the previous setting, idle immediate keeps it
        send(OP_IDLE_A, 8'hf1);
        check({7'h0, cmd_irq}, 8'h01);
        send(OP_IDLE_B, TMO_21MIN);
        check({7'h0, cmd_irq}, 8'h01);
        send(OP_STBY_B, TMO_VENDOR);
        check(8'(pm_state), 8'(PM_STANDBY));
        send(OP_IDLE_IMM_B, 8'h00);
        check(8'(pm_state), 8'(PM_IDLE));
        $display("test long timeout codes done");

        send(OP_SLEEP_B, 8'h00);
        check({5'h0, spin_down_req, busy_status_flag, cmd_irq}, 8'h06);
        wait_busy_low(40);
        check({7'h0, cmd_irq}, 8'h01);
        check(8'(pm_state), 8'(PM_SLEEP));
        send(OP_IDLE_IMM_A, 8'h00);
        check({7'h0, cmd_irq}, 8'h00);
        check(8'(pm_state), 8'(PM_SLEEP));
        @(negedge ref_clk);
        soft_reset = 1'b1;
        @(negedge ref_clk);
        soft_reset = 1'b0;
        check(8'(pm_state), 8'(PM_ACTIVE));
        send(OP_STBY_IMM_A, 8'h00);
        check({7'h0, cmd_irq}, 8'h01);
        $display("test sleep and wake done");

        repeat (5) @(negedge ref_clk);
        check(8'(exp_q.size()), 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
